// [verilog/rtct_timer.v]
// countdown timer with shared interrupt line and rate trim, reached
// over a 4-bit banked parallel bus with write and read strobes.
// assumes bus inputs are synchronous to clk_in and stable at the
// rising edge of the write strobe.
//
// Operation
// - count reaching zero sets timer flag
// - flag held until host writes zero
// - run enable gates the countdown
// - irq enable off keeps line released
// - level mode holds line low until cleared
// - repeat mode pulses line, flag stays set
// - level mode stops at zero, clears run
// - repeat mode reloads preset and continues
// - alarm or timer may pull shared line
// - live count readable, writes ignored
// - preset write loads counter, preset kept
// - zero preset never raises timer event
// - first period short by up to one tick
// - counting starts at write strobe rise
// - stop halts at once, no late tick fires
// - interval is preset times source period
// - trim adjusts one second in ten
// - trim is signed seven-bit, 3.05 ppm step
// - control regs E and F in every bank
// - source select picks timer tick rate
// - repeat pulse width depends on source
// - trim gated by chip select one unless overridden
// - bank selector picks bank, 11 aliases 1
`timescale 1ns/1ps
`include "rtct_regs.vh"

module rtct_timer #(
    parameter CLK_HZ   = `RTCT_CLK_HZ,
    parameter RTN_FAST = (`RTCT_RTN_FAST_NS / `RTCT_CLK_PERIOD_NS),
    parameter RTN_SLOW = (`RTCT_RTN_SLOW_NS / `RTCT_CLK_PERIOD_NS)
) (
    input  wire       clk_in,
    input  wire       sys_rst_in,
    input  wire [3:0] addr_in,
    input  wire [3:0] data_in,
    input  wire       write_strobe_n_in,
    input  wire       read_strobe_n_in,
    input  wire       chip_select_one_in,
    input  wire       alarm_event_in,
    output reg  [3:0] data_out,
    output reg        data_oe_out,
    output reg        irq_out_n_out,
    output reg        irq_oe_out
);

    localparam [20:0] RTN_FAST_CNT = RTN_FAST[20:0];
    localparam [20:0] RTN_SLOW_CNT = RTN_SLOW[20:0];

    // ************************************************************
    // registers
    // ************************************************************
    reg  [6:0]  trim_value_reg;
    reg         trim_enable_reg;
    reg         trim_gate_override_reg;
    reg  [7:0]  preset_reg;
    reg  [7:0]  count_reg;
    reg  [1:0]  timer_clock_select_reg;
    reg         timer_irq_enable_reg;
    reg         timer_irq_mode_reg;
    reg         timer_run_enable_reg;
    reg         timer_flag_reg;
    reg         alarm_irq_enable_reg;
    reg         alarm_flag_reg;
    reg  [1:0]  ctrl_low_reg;
    reg  [1:0]  bank_selector_reg;
    reg         stop_reg;
    reg         wr_prev_reg;
    reg  [20:0] pulse_cnt_reg;

    wire        wr_rise;
    wire [1:0]  bank;
    wire        wr_common;
    wire        wr_timer;
    wire        wr_alarm;
    wire        tick_4096;
    wire        tick_64;
    wire        tick_sec;
    wire        tick_min;
    reg         src_tick;
    wire        trim_active;
    wire        timer_event;
    reg  [3:0]  rd_mux;

    // ************************************************************
    // bus decode
    // ************************************************************
    // writes take effect on the rising edge of the write strobe
    assign wr_rise   = write_strobe_n_in & ~wr_prev_reg;
    assign bank      = (bank_selector_reg == `RTCT_BANK_ALIAS) ?
                       `RTCT_BANK_ALARM : bank_selector_reg;
    assign wr_common = wr_rise && (addr_in == `RTCT_OFS_CTRL_LOW ||
                       addr_in == `RTCT_OFS_CTRL_HIGH);
    assign wr_timer  = wr_rise && !wr_common &&
                       bank == `RTCT_BANK_TIMER;
    assign wr_alarm  = wr_rise && !wr_common &&
                       bank == `RTCT_BANK_ALARM;

    // ************************************************************
    // timebase
    // ************************************************************
    assign trim_active = trim_enable_reg &&
                         (trim_gate_override_reg || chip_select_one_in);

    rtct_tick_gen #(
        .CLK_HZ         (CLK_HZ)
    ) u_tick_gen (
        .clk_in         (clk_in),
        .sys_rst_in     (sys_rst_in),
        .trim_active_in (trim_active),
        .trim_value_in  (trim_value_reg),
        .tick_4096_out  (tick_4096),
        .tick_64_out    (tick_64),
        .tick_sec_out   (tick_sec),
        .tick_min_out   (tick_min)
    );

    // free-running ticks are not aligned to the start, so the first
    // period may run short by up to one source period
    always @* begin
        case (timer_clock_select_reg)
            `RTCT_SRC_4096HZ: src_tick = tick_4096;
            `RTCT_SRC_64HZ:   src_tick = tick_64;
            `RTCT_SRC_SECOND: src_tick = tick_sec;
            default:          src_tick = tick_min;
        endcase
    end

    // zero reached by counting down; a zero preset never gets here
    assign timer_event = timer_run_enable_reg && src_tick &&
                         count_reg == 8'h01;

    // ************************************************************
    // register writes and countdown
    // ************************************************************
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_prev_reg            <= 1'b1;
            trim_value_reg         <= 7'h00;
            trim_enable_reg        <= 1'b0;
            trim_gate_override_reg <= 1'b0;
            preset_reg             <= `RTCT_RST_BYTE;
            count_reg              <= `RTCT_RST_BYTE;
            timer_clock_select_reg <= `RTCT_SRC_4096HZ;
            timer_irq_enable_reg   <= 1'b0;
            timer_irq_mode_reg     <= 1'b0;
            timer_run_enable_reg   <= 1'b0;
            timer_flag_reg         <= 1'b0;
            alarm_irq_enable_reg   <= 1'b0;
            alarm_flag_reg         <= 1'b0;
            ctrl_low_reg           <= 2'h0;
            bank_selector_reg      <= `RTCT_BANK_CLOCK;
            stop_reg               <= 1'b0;
        end else begin
            wr_prev_reg <= write_strobe_n_in;

            // countdown; halts at once when run enable drops
            if (timer_run_enable_reg && src_tick) begin
                if (count_reg != 8'h00) begin
                    count_reg <= count_reg - 8'h01;
                end
                if (timer_event && timer_irq_mode_reg) begin
                    count_reg <= preset_reg;
                end
                if (timer_event && !timer_irq_mode_reg) begin
                    timer_run_enable_reg <= 1'b0;
                end
            end

            if (wr_timer) begin
                case (addr_in)
                    `RTCT_OFS_TRIM_LOW:
                        trim_value_reg[3:0] <= data_in;
                    `RTCT_OFS_TRIM_HIGH: begin
                        trim_value_reg[6:4] <= data_in[2:0];
                        trim_enable_reg <= data_in[`RTCT_BIT_TRIM_ENABLE];
                    end
                    `RTCT_OFS_PRESET_LOW: begin
                        preset_reg[3:0] <= data_in;
                        count_reg <= {preset_reg[7:4], data_in};
                    end
                    `RTCT_OFS_PRESET_HIGH: begin
                        preset_reg[7:4] <= data_in;
                        count_reg <= {data_in, preset_reg[3:0]};
                    end
                    `RTCT_OFS_TIMER_SRC:
                        timer_clock_select_reg <= data_in[1:0];
                    `RTCT_OFS_TIMER_CTRL: begin
                        timer_irq_enable_reg <=
                            data_in[`RTCT_BIT_TIMER_IRQ_EN];
                        timer_irq_mode_reg <= data_in[`RTCT_BIT_TIMER_MODE];
                        timer_run_enable_reg <=
                            data_in[`RTCT_BIT_TIMER_RUN];
                    end
                    // live count registers ignore writes
                    default: ;
                endcase
            end

            if (wr_alarm && addr_in == `RTCT_OFS_ALARM_CTRL) begin
                alarm_irq_enable_reg <= data_in[`RTCT_BIT_ALARM_IRQ_EN];
            end
            if (wr_alarm && addr_in == `RTCT_OFS_TRIM_GATE) begin
                trim_gate_override_reg <=
                    data_in[`RTCT_BIT_TRIM_OVERRIDE];
            end

            if (wr_common && addr_in == `RTCT_OFS_CTRL_LOW) begin
                ctrl_low_reg <= data_in[3:2];
            end
            if (wr_common && addr_in == `RTCT_OFS_CTRL_HIGH) begin
                bank_selector_reg <= data_in[3:2];
                stop_reg          <= data_in[1];
            end

            // flags: only a written zero clears, and a set in the same
            // cycle wins over the clear
            if (wr_timer && addr_in == `RTCT_OFS_TIMER_CTRL &&
                !data_in[`RTCT_BIT_TIMER_FLAG]) begin
                timer_flag_reg <= 1'b0;
            end
            if (timer_event) begin
                timer_flag_reg <= 1'b1;
            end
            if (wr_alarm && addr_in == `RTCT_OFS_ALARM_CTRL &&
                !data_in[`RTCT_BIT_ALARM_FLAG]) begin
                alarm_flag_reg <= 1'b0;
            end
            if (alarm_event_in) begin
                alarm_flag_reg <= 1'b1;
            end
        end
    end

    // ************************************************************
    // interrupt line
    // ************************************************************
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pulse_cnt_reg <= 21'h000000;
            irq_out_n_out <= 1'b1;
            irq_oe_out    <= 1'b0;
        end else begin
            // repeat mode release pulse; retriggers on every event while irq enabled
            if (timer_event && timer_irq_mode_reg &&
                timer_irq_enable_reg) begin
                pulse_cnt_reg <= (timer_clock_select_reg ==
                                  `RTCT_SRC_4096HZ) ?
                                 RTN_FAST_CNT : RTN_SLOW_CNT;
            end else if (pulse_cnt_reg != 21'h000000) begin
                pulse_cnt_reg <= pulse_cnt_reg - 21'h000001;
            end
            // line is only ever pulled low, never driven high
            irq_out_n_out <= 1'b0;
            irq_oe_out    <= (alarm_flag_reg && alarm_irq_enable_reg) ||
                             (timer_irq_enable_reg &&
                              ((!timer_irq_mode_reg && timer_flag_reg) ||
                               (timer_irq_mode_reg &&
                                pulse_cnt_reg != 21'h000000)));
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    always @* begin
        rd_mux = 4'h0;
        if (addr_in == `RTCT_OFS_CTRL_LOW) begin
            rd_mux = {ctrl_low_reg, 2'b00};
        end else if (addr_in == `RTCT_OFS_CTRL_HIGH) begin
            rd_mux = {bank_selector_reg, stop_reg, 1'b0};
        end else if (bank == `RTCT_BANK_TIMER) begin
            case (addr_in)
                `RTCT_OFS_TRIM_LOW:    rd_mux = trim_value_reg[3:0];
                `RTCT_OFS_TRIM_HIGH:   rd_mux = {trim_enable_reg,
                                                 trim_value_reg[6:4]};
                `RTCT_OFS_PRESET_LOW:  rd_mux = preset_reg[3:0];
                `RTCT_OFS_PRESET_HIGH: rd_mux = preset_reg[7:4];
                `RTCT_OFS_LIVE_LOW:    rd_mux = count_reg[3:0];
                `RTCT_OFS_LIVE_HIGH:   rd_mux = count_reg[7:4];
                `RTCT_OFS_TIMER_SRC:   rd_mux = {2'b00,
                                                 timer_clock_select_reg};
                `RTCT_OFS_TIMER_CTRL:  rd_mux = {timer_irq_enable_reg,
                                                 timer_irq_mode_reg,
                                                 timer_run_enable_reg,
                                                 timer_flag_reg};
                default:               rd_mux = 4'h0;
            endcase
        end else if (bank == `RTCT_BANK_ALARM) begin
            case (addr_in)
                `RTCT_OFS_ALARM_CTRL: rd_mux = {2'b00,
                                                alarm_irq_enable_reg,
                                                alarm_flag_reg};
                `RTCT_OFS_TRIM_GATE:  rd_mux = {1'b0,
                                                trim_gate_override_reg,
                                                2'b00};
                default:              rd_mux = 4'h0;
            endcase
        end
    end

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            data_out    <= 4'h0;
            data_oe_out <= 1'b0;
        end else begin
            data_out    <= rd_mux;
            data_oe_out <= !read_strobe_n_in;
        end
    end

endmodule

// [shared/rtct_regs.vh]
// register map, field positions, reset values and timing constants
// for the countdown timer and rate trim block.
// assumes a 4-bit banked register bus and a 200 MHz system clock.
`ifndef RTCT_REGS_VH
`define RTCT_REGS_VH

// ************************************************************
// register offsets
// ************************************************************
`define RTCT_OFS_TRIM_LOW       4'h0
`define RTCT_OFS_TRIM_HIGH      4'h1
`define RTCT_OFS_PRESET_LOW     4'h4
`define RTCT_OFS_PRESET_HIGH    4'h5
`define RTCT_OFS_LIVE_LOW       4'h6
`define RTCT_OFS_LIVE_HIGH      4'h7
`define RTCT_OFS_TIMER_SRC      4'h8
`define RTCT_OFS_TIMER_CTRL     4'h9
`define RTCT_OFS_ALARM_CTRL     4'h9
`define RTCT_OFS_TRIM_GATE      4'hb
`define RTCT_OFS_CTRL_LOW       4'he
`define RTCT_OFS_CTRL_HIGH      4'hf

// ************************************************************
// banks
// ************************************************************
`define RTCT_BANK_CLOCK         2'h0
`define RTCT_BANK_ALARM         2'h1
`define RTCT_BANK_TIMER         2'h2
`define RTCT_BANK_ALIAS         2'h3

// ************************************************************
// field positions
// ************************************************************
`define RTCT_BIT_TRIM_ENABLE    3
`define RTCT_BIT_TIMER_IRQ_EN   3
`define RTCT_BIT_TIMER_MODE     2
`define RTCT_BIT_TIMER_RUN      1
`define RTCT_BIT_TIMER_FLAG     0
`define RTCT_BIT_ALARM_IRQ_EN   1
`define RTCT_BIT_ALARM_FLAG     0
`define RTCT_BIT_TRIM_OVERRIDE  2

// ************************************************************
// timer source codes
// ************************************************************
`define RTCT_SRC_4096HZ         2'h0
`define RTCT_SRC_64HZ           2'h1
`define RTCT_SRC_SECOND         2'h2
`define RTCT_SRC_MINUTE         2'h3

// ************************************************************
// reset values
// ************************************************************
`define RTCT_RST_NIBBLE         4'h0
`define RTCT_RST_BYTE           8'h00

// ************************************************************
// timing
// ************************************************************
`define RTCT_CLK_HZ             200000000
`define RTCT_TIMEBASE_HZ        32768
`define RTCT_TICKS_PER_SECOND   32768
`define RTCT_SECONDS_PER_MINUTE 60
`define RTCT_TRIM_PERIOD_S      10
`define RTCT_RTN_FAST_NS        122000
`define RTCT_RTN_SLOW_NS        7810000
`define RTCT_CLK_PERIOD_NS      5

`endif

// [verilog/rtct_tick_gen.v]
// timebase for the countdown timer: a 32.768 kHz enable made from the
// system clock, split into 4096 Hz, 64 Hz, second and minute pulses.
// assumes one clock; the second is stretched or shortened by the trim.
`timescale 1ns/1ps
`include "rtct_regs.vh"

module rtct_tick_gen #(
    parameter CLK_HZ = `RTCT_CLK_HZ
) (
    input  wire       clk_in,
    input  wire       sys_rst_in,
    input  wire       trim_active_in,
    input  wire [6:0] trim_value_in,
    output reg        tick_4096_out,
    output reg        tick_64_out,
    output reg        tick_sec_out,
    output reg        tick_min_out
);

    localparam        ACC_STEP_I  = `RTCT_TIMEBASE_HZ;
    localparam        SEC_LAST_I  = `RTCT_TICKS_PER_SECOND - 1;
    localparam        TRIM_LAST_I = `RTCT_TRIM_PERIOD_S - 1;
    localparam        MIN_LAST_I  = `RTCT_SECONDS_PER_MINUTE - 1;
    localparam [27:0] ACC_STEP    = ACC_STEP_I[27:0];
    localparam [27:0] ACC_WRAP    = CLK_HZ[27:0];
    localparam [15:0] SEC_LAST    = SEC_LAST_I[15:0];
    localparam [3:0]  TRIM_LAST   = TRIM_LAST_I[3:0];
    localparam [5:0]  MIN_LAST    = MIN_LAST_I[5:0];

    reg  [27:0] acc_reg;
    reg  [15:0] sub_reg;
    reg  [3:0]  ten_reg;
    reg  [5:0]  min_reg;
    wire [27:0] acc_sum;
    wire        base_tick;
    wire [15:0] sec_limit;

    // ************************************************************
    // fractional divider to the 32.768 kHz rate
    // ************************************************************
    // accumulator keeps long-term rate exact despite 200e6/32768
    // not being whole; jitter is one system clock
    assign acc_sum   = acc_reg + ACC_STEP;
    assign base_tick = (acc_sum >= ACC_WRAP);

    // one second in ten is trimmed by one timebase tick per step
    assign sec_limit = (trim_active_in && ten_reg == TRIM_LAST) ?
                       SEC_LAST + {{9{trim_value_in[6]}}, trim_value_in} :
                       SEC_LAST;

    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            acc_reg       <= 28'h0000000;
            sub_reg       <= 16'h0000;
            ten_reg       <= 4'h0;
            min_reg       <= 6'h00;
            tick_4096_out <= 1'b0;
            tick_64_out   <= 1'b0;
            tick_sec_out  <= 1'b0;
            tick_min_out  <= 1'b0;
        end else begin
            acc_reg       <= base_tick ? acc_sum - ACC_WRAP : acc_sum;
            tick_4096_out <= base_tick && (sub_reg[2:0] == 3'h7);
            tick_64_out   <= base_tick && (sub_reg[8:0] == 9'h1ff);
            tick_sec_out  <= 1'b0;
            tick_min_out  <= 1'b0;
            if (base_tick) begin
                if (sub_reg >= sec_limit) begin
                    sub_reg      <= 16'h0000;
                    tick_sec_out <= 1'b1;
                    ten_reg      <= (ten_reg == TRIM_LAST) ? 4'h0 :
                                    ten_reg + 4'h1;
                    if (min_reg == MIN_LAST) begin
                        min_reg      <= 6'h00;
                        tick_min_out <= 1'b1;
                    end else begin
                        min_reg <= min_reg + 6'h01;
                    end
                end else begin
                    sub_reg <= sub_reg + 16'h0001;
                end
            end
        end
    end

endmodule

// [testbench/rtct_timer_asserts.sv]
// port checker for the countdown timer block
// assumes one clock and a host that keeps the write strobe high at reset
`timescale 1ns/1ps
module rtct_timer_asserts #(
    parameter RTN_FAST = 20,
    parameter RTN_SLOW = 50
) (
    input wire logic       clk_in,
    input wire logic       sys_rst_in,
    input wire logic [3:0] addr_in,
    input wire logic [3:0] data_in,
    input wire logic       write_strobe_n_in,
    input wire logic       read_strobe_n_in,
    input wire logic [3:0] data_out,
    input wire logic       data_oe_out,
    input wire logic       irq_out_n_out,
    input wire logic       irq_oe_out
);
// ************************************************************
// mirror of the bus writes that the checks depend on
// ************************************************************
logic       prev_wr_n;
logic [1:0] bank_reg;
logic [1:0] src_reg;
logic       tie_reg;
logic       mode_reg;
logic       aie_reg;
int         hcnt_reg;
wire wr_taken = write_strobe_n_in & ~prev_wr_n;
wire in_bank2 = (bank_reg == 2'h2);
always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
        prev_wr_n <= 1'b1;
        bank_reg <= 2'h0;
        src_reg <= 2'h0;
        tie_reg <= 1'b0;
        mode_reg <= 1'b0;
        aie_reg <= 1'b0;
        hcnt_reg <= 0;
    end else begin
        prev_wr_n <= write_strobe_n_in;
        hcnt_reg <= irq_oe_out ? hcnt_reg + 1 : 0;
        if (wr_taken && addr_in == 4'hf) bank_reg <= data_in[3:2];
        if (wr_taken && in_bank2 && addr_in == 4'h8) src_reg <= data_in[1:0];
        if (wr_taken && in_bank2 && addr_in == 4'h9) begin
            tie_reg <= data_in[3];
            mode_reg <= data_in[2];
        end
        // bank 3 aliases bank 1, so bit 0 alone marks the alarm bank
        if (wr_taken && bank_reg[0] && addr_in == 4'h9) aie_reg <= data_in[1];
    end
end
default clocking cb @(posedge clk_in); endclocking
default disable iff (sys_rst_in);
property p_unmasked_rise; $rose(irq_oe_out) |-> (tie_reg || aie_reg); endproperty
a_unmasked_rise: assert property (p_unmasked_rise)
    else $error("irq rose with both enables off");
property p_fast_width;
    $fell(irq_oe_out) && mode_reg && src_reg == 2'h0
    |-> hcnt_reg >= RTN_FAST && hcnt_reg <= RTN_FAST + 1;
endproperty
a_fast_width: assert property (p_fast_width)
    else $error("fast repeat pulse width wrong");
property p_slow_width;
    $fell(irq_oe_out) && mode_reg && src_reg != 2'h0
    |-> hcnt_reg >= RTN_SLOW && hcnt_reg <= RTN_SLOW + 1;
endproperty
a_slow_width: assert property (p_slow_width)
    else $error("slow repeat pulse width wrong");
property p_level_hold;
    irq_oe_out && !mode_reg && !wr_taken && !$past(wr_taken) |=> irq_oe_out;
endproperty
a_level_hold: assert property (p_level_hold)
    else $error("level irq released without a write");
property p_flag_release;
    wr_taken && in_bank2 && addr_in == 4'h9 && !data_in[0] && !mode_reg
    && !aie_reg |-> ##[1:2] !irq_oe_out;
endproperty
a_flag_release: assert property (p_flag_release)
    else $error("irq held after flag clear");
property p_oe_on; !read_strobe_n_in |=> data_oe_out; endproperty
a_oe_on: assert property (p_oe_on)
    else $error("read data not driven");
property p_oe_off; read_strobe_n_in |=> !data_oe_out; endproperty
a_oe_off: assert property (p_oe_off)
    else $error("read data driven while idle");
property p_pin; irq_oe_out |-> !irq_out_n_out; endproperty
a_pin: assert property (p_pin)
    else $error("irq pin value high while enabled");
property p_unmapped;
    !read_strobe_n_in && in_bank2 && addr_in == 4'h2 |=> data_out == 4'h0;
endproperty
a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule

bind rtct_timer rtct_timer_asserts #(
    .RTN_FAST(RTN_FAST),
    .RTN_SLOW(RTN_SLOW)
) rtct_timer_asserts_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
    .data_in(data_in), .write_strobe_n_in(write_strobe_n_in),
    .read_strobe_n_in(read_strobe_n_in), .data_out(data_out),
    .data_oe_out(data_oe_out), .irq_out_n_out(irq_out_n_out),
    .irq_oe_out(irq_oe_out)
);

// [testbench/rtct_host_model.sv]
// host processor model driving the banked strobe bus
// assumes it is the only master; all changes land on the falling edge
`timescale 1ns/1ps
module rtct_host_model (
    input  wire logic       clk_in,
    input  wire logic [3:0] rd_data_in,
    output logic      [3:0] addr_out,
    output logic      [3:0] wdata_out,
    output logic            wr_n_out,
    output logic            rd_n_out
);
initial begin
    addr_out = 4'h0;
    wdata_out = 4'h0;
    wr_n_out = 1'b1;
    rd_n_out = 1'b1;
end
task automatic wr(input logic [3:0] a, input logic [3:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_n_out = 1'b0;
    @(negedge clk_in);
    wr_n_out = 1'b1;
    @(negedge clk_in);
    // a released bus must not look like the last write
    wdata_out = ~d;
endtask
task automatic rd(input logic [3:0] a, output logic [3:0] d);
    @(negedge clk_in);
    addr_out = a;
    rd_n_out = 1'b0;
    @(negedge clk_in);
    d = rd_data_in;
    rd_n_out = 1'b1;
endtask
endmodule

// [testbench/rtct_timer_tb.sv]
// self-checking bench for the countdown timer block
// assumes a shortened timebase: one 32768 Hz tick every two clocks
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin \
    n_fail++; $display("mismatch %s expected %h seen %h", nm, exp, got); \
    end end
module rtct_timer_tb;
logic       clk_in = 1'b0;
logic       sys_rst_in = 1'b1;
logic       alarm_ev = 1'b0;
logic [3:0] addr, wdata, rdata, d;
logic       wr_n, rd_n, data_oe, irq_n, irq_oe, seen;
int         compares = 0;
int         n_fail = 0;
int         n;
rtct_timer #(.CLK_HZ(65536), .RTN_FAST(20), .RTN_SLOW(50)) rtct_timer_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr),
    .data_in(wdata), .write_strobe_n_in(wr_n), .read_strobe_n_in(rd_n),
    .chip_select_one_in(1'b1), .alarm_event_in(alarm_ev),
    .data_out(rdata), .data_oe_out(data_oe), .irq_out_n_out(irq_n),
    .irq_oe_out(irq_oe));
rtct_host_model rtct_host_model_i (.clk_in(clk_in), .rd_data_in(rdata),
    .addr_out(addr), .wdata_out(wdata), .wr_n_out(wr_n), .rd_n_out(rd_n));
initial begin
    forever #2.5 clk_in = ~clk_in;
end
task automatic w(input logic [3:0] a, input logic [3:0] v);
    rtct_host_model_i.wr(a, v);
endtask
task automatic r(input logic [3:0] a, input logic [3:0] exp);
    rtct_host_model_i.rd(a, d);
    `CHK("read", exp, d)
endtask
task automatic wait_irq(input logic v, input int lim);
    n = 0;
    while (irq_oe !== v && n < lim) begin
        @(negedge clk_in);
        n++;
    end
    `CHK("irq_oe", v, irq_oe)
endtask
task automatic quiet(input int cyc);
    seen = 1'b0;
    repeat (cyc) begin
        @(negedge clk_in);
        seen = seen | irq_oe;
    end
    `CHK("irq_quiet", 1'b0, seen)
endtask
task print_verdict;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
endtask
initial begin
    repeat (30000) @(posedge clk_in);
    n_fail++;
    print_verdict();
end
// ************************************************************
// scenarios
// ************************************************************
initial begin
    repeat (6) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    w(4'hf, 4'h8);
    w(4'h1, 4'h0);
    w(4'h0, 4'h9);
    r(4'h0, 4'h9);
    r(4'h1, 4'h0);
    r(4'h6, 4'h0);
    w(4'h4, 4'h2);
    w(4'h5, 4'h0);
    w(4'h6, 4'hf);
    r(4'h6, 4'h2);
    r(4'h4, 4'h2);
    r(4'h2, 4'h0);
    w(4'h9, 4'hb);
    wait_irq(1'b1, 100);
    // two ticks of 16 clocks, first may be short by one tick
    `CHK("interval", 1'b1, (n > 14) && (n < 37))
    r(4'h9, 4'h9);
    r(4'h6, 4'h0);
    w(4'h9, 4'h9);
    r(4'h9, 4'h9);
    `CHK("irq_held", 1'b1, irq_oe)
    w(4'h9, 4'h8);
    wait_irq(1'b0, 4);
    w(4'h4, 4'h2);
    w(4'h9, 4'h2);
    quiet(120);
    r(4'h9, 4'h1);
    w(4'h9, 4'h0);
    w(4'h4, 4'h0);
    w(4'h9, 4'ha);
    quiet(120);
    r(4'h9, 4'ha);
    for (int s = 0; s < 2; s++) begin
        w(4'h9, 4'h0);
        w(4'h8, s[3:0]);
        w(4'h4, 4'h3);
        w(4'h9, 4'he);
        wait_irq(1'b1, 3200);
        wait_irq(1'b0, 60);
        r(4'h9, 4'hf);
        wait_irq(1'b1, 3200);
        wait_irq(1'b0, 60);
        w(4'h9, 4'hc);
        // stopped with the irq still enabled: no late event may follow
        quiet(40);
    end
    w(4'h9, 4'h0);
    w(4'hf, 4'hc);
    w(4'h9, 4'h2);
    @(negedge clk_in);
    alarm_ev = 1'b1;
    @(negedge clk_in);
    alarm_ev = 1'b0;
    wait_irq(1'b1, 8);
    r(4'hf, 4'hc);
    r(4'h9, 4'h3);
    w(4'hf, 4'h4);
    r(4'h9, 4'h3);
    w(4'h9, 4'h2);
    wait_irq(1'b0, 4);
    print_verdict();
end
endmodule
